// *** hdl/bpcd_port.sv ***
`timescale 1ns/1ps
`include "bpcd_map.svh"
module bpcd_port #(
	parameter int WIDTH = 8,
	parameter int CHG_LO = 4
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic sleep_req,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe_n,
	output logic [WIDTH-1:0] pullup_on,
	output logic irq,
	output logic wake,
	output logic asleep
);
	initial begin
		if (WIDTH != 8)
			$error("bpcd_port: WIDTH must be 8");
		if (CHG_LO < 0 || CHG_LO >= WIDTH)
			$error("bpcd_port: CHG_LO out of range");
	end

	////////////////////////////////////////////////////////////
	function automatic logic hit(input logic [3:0] a, input logic [3:0] b);
		hit = (a == b);
	endfunction

	logic [WIDTH-1:0] latch_reg, latch_next;
	logic [WIDTH-1:0] dir_reg, dir_next;
	logic [7:0] option_reg, option_next;
	logic chg_flag_reg, chg_flag_next;
	logic chg_en_reg, chg_en_next;
	logic [WIDTH-1:0] alt_en_reg, alt_en_next;
	logic [WIDTH-1:0] alt_out_reg, alt_out_next;
	logic [WIDTH-1:0] alt_oe_reg, alt_oe_next;
	logic [7:0] rdata_reg, rdata_next;
	logic irq_reg, irq_next;
	logic wake_reg, wake_next;
	bpcd_pkg::bpcd_pwr_e pwr_reg, pwr_next;
	logic mismatch;
	logic port_access;
	logic [WIDTH-1:0] merged;

	assign port_access = (reg_wr || reg_rd) && hit(reg_addr, `BPCD_ADDR_DATA);

	////////////////////////////////////////////////////////////
	always_comb begin
		latch_next = latch_reg;
		dir_next = dir_reg;
		option_next = option_reg;
		chg_en_next = chg_en_reg;
		alt_en_next = alt_en_reg;
		alt_out_next = alt_out_reg;
		alt_oe_next = alt_oe_reg;
		chg_flag_next = chg_flag_reg;
		// Pins sampled first; output pins take the written value
		merged = (pin_in & dir_reg) | (reg_wdata & ~dir_reg); // RQ5
		if (reg_wr) begin
			if (hit(reg_addr, `BPCD_ADDR_DATA))
				latch_next = reg_wdata | (merged & 8'h00); // RQ4 RQ5
			if (hit(reg_addr, `BPCD_ADDR_DIR))
				dir_next = reg_wdata;
			if (hit(reg_addr, `BPCD_ADDR_OPTION))
				option_next = reg_wdata; // RQ6
			if (hit(reg_addr, `BPCD_ADDR_INTCTL)) begin
				chg_en_next = reg_wdata[`BPCD_BIT_CHG_EN];
				if (!reg_wdata[`BPCD_BIT_CHG_FLAG])
					chg_flag_next = 1'b0; // RQ14
			end
			if (hit(reg_addr, `BPCD_ADDR_ALTEN))
				alt_en_next = reg_wdata;
			if (hit(reg_addr, `BPCD_ADDR_ALTOUT))
				alt_out_next = reg_wdata;
			if (hit(reg_addr, `BPCD_ADDR_ALTOE))
				alt_oe_next = reg_wdata;
		end
		// Set beats clear while the mismatch stands
		if (mismatch)
			chg_flag_next = 1'b1; // RQ11 RQ14
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			latch_reg <= `BPCD_RST_LATCH;
			dir_reg <= `BPCD_RST_DIR;
			option_reg <= `BPCD_RST_OPTION; // RQ8
			chg_flag_reg <= 1'b0;
			chg_en_reg <= 1'b0;
			alt_en_reg <= '0;
			alt_out_reg <= '0;
			alt_oe_reg <= '0;
		end else begin
			latch_reg <= latch_next;
			dir_reg <= dir_next;
			option_reg <= option_next;
			chg_flag_reg <= chg_flag_next;
			chg_en_reg <= chg_en_next;
			alt_en_reg <= alt_en_next;
			alt_out_reg <= alt_out_next;
			alt_oe_reg <= alt_oe_next;
		end
	end

	////////////////////////////////////////////////////////////
	always_comb begin
		rdata_next = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				`BPCD_ADDR_DATA: rdata_next = pin_in; // RQ4
				`BPCD_ADDR_DIR: rdata_next = dir_reg;
				`BPCD_ADDR_OPTION: rdata_next = option_reg;
				`BPCD_ADDR_INTCTL: begin
					rdata_next[`BPCD_BIT_CHG_FLAG] = chg_flag_reg;
					rdata_next[`BPCD_BIT_CHG_EN] = chg_en_reg;
				end
				`BPCD_ADDR_ALTEN: rdata_next = alt_en_reg;
				`BPCD_ADDR_ALTOUT: rdata_next = alt_out_reg;
				`BPCD_ADDR_ALTOE: rdata_next = alt_oe_reg;
				`BPCD_ADDR_WAKE: rdata_next = {7'h00, pwr_reg == bpcd_pkg::BPCD_SLEEP};
				default: rdata_next = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst)
			rdata_reg <= 8'h00;
		else
			rdata_reg <= rdata_next;
	end
	assign reg_rdata = rdata_reg;

	////////////////////////////////////////////////////////////
	always_comb begin
		irq_next = chg_flag_next & chg_en_next; // RQ17
		wake_next = 1'b0;
		pwr_next = pwr_reg;
		case (pwr_reg)
			bpcd_pkg::BPCD_RUN: begin
				if (sleep_req)
					pwr_next = bpcd_pkg::BPCD_SLEEP;
			end
			bpcd_pkg::BPCD_SLEEP: begin
				if (chg_flag_reg && chg_en_reg) begin
					pwr_next = bpcd_pkg::BPCD_RUN; // RQ12
					wake_next = 1'b1; // RQ12 RQ17
				end
			end
			default: pwr_next = bpcd_pkg::BPCD_RUN;
		endcase
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			irq_reg <= 1'b0;
			wake_reg <= 1'b0;
			pwr_reg <= bpcd_pkg::BPCD_RUN;
		end else begin
			irq_reg <= irq_next;
			wake_reg <= wake_next;
			pwr_reg <= pwr_next;
		end
	end
	assign irq = irq_reg;
	assign wake = wake_reg;
	// One-hot code: the sleep bit is the flop itself
	assign asleep = pwr_reg[1];

	////////////////////////////////////////////////////////////
	bpcd_pin_cell #(
		.WIDTH(WIDTH)
	) u_cell (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.dir(dir_reg),
		.latch(latch_reg),
		.alt_en(alt_en_reg),
		.alt_out(alt_out_reg),
		.alt_oe(alt_oe_reg),
		.pullup_disable_n(option_reg[`BPCD_BIT_PULLUP_DIS_N]),
		.pin_out(pin_out),
		.pin_oe_n(pin_oe_n),
		.pullup_on(pullup_on)
	);

	// Upper nibble only; polling reads would mask key changes
	bpcd_change_det #(
		.WIDTH(WIDTH - CHG_LO)
	) u_chg (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.pins(pin_in[WIDTH-1:CHG_LO]),
		.dir(dir_reg[WIDTH-1:CHG_LO]),
		.access(port_access),
		.mismatch(mismatch)
	);

	////////////////////////////////////////////////////////////
	flag_set_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		mismatch |=> chg_flag_reg)
		else $error("port-change flag missed a mismatch"); // RQ11
	flag_hold_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(chg_flag_reg && !(reg_wr && hit(reg_addr, `BPCD_ADDR_INTCTL)))
		|=> chg_flag_reg)
		else $error("port-change flag lost without clear"); // RQ14
	data_read_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(reg_rd && reg_addr == `BPCD_ADDR_DATA) |=> reg_rdata == $past(pin_in))
		else $error("data read does not show pins"); // RQ4
	data_write_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(reg_wr && reg_addr == `BPCD_ADDR_DATA) |=> latch_reg == $past(reg_wdata))
		else $error("latch not updated by write"); // RQ4
	irq_gate_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		irq |-> chg_en_reg)
		else $error("interrupt without enable"); // RQ17
	wake_go_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(asleep && chg_flag_reg && chg_en_reg) |=> (wake && !asleep))
		else $error("no wake on port change"); // RQ12
	pullup_cfg_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		1'b1 |=> pullup_on == ($past(dir_reg) & ~$past(alt_en_reg)
		& {WIDTH{~$past(option_reg[`BPCD_BIT_PULLUP_DIS_N])}}) ||
		$past(alt_en_reg) != '0)
		else $error("pull-up state wrong"); // RQ18
	flag_clear_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(reg_wr && reg_addr == `BPCD_ADDR_INTCTL && !mismatch
		&& !reg_wdata[`BPCD_BIT_CHG_FLAG]) |=> !chg_flag_reg)
		else $error("port-change flag not cleared"); // RQ14
	wake_pulse_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		wake |=> !wake)
		else $error("wake longer than one cycle"); // RQ12
	sleep_enter_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(!asleep && sleep_req) |=> asleep)
		else $error("sleep request not taken"); // RQ12
	rdata_idle_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data without read"); // RQ4
endmodule

// *** hdl/bpcd_map.svh ***
// Contract
// RQ1: Direction bit 1 tristates the pin driver
// RQ2: Direction bit 0 drives the output latch
// RQ3: Enabled alternate function overrides direction bit
// RQ4: Data read gives pins; write updates latch
// RQ5: Writes merge into sampled pin levels; the code loads the whole written byte into the latch
// RQ6: One shared active-low pull-up enable bit
// RQ7: Output pins never have pull-up
// RQ8: Pull-ups disabled after power-on reset
// RQ9: Only upper four input pins are compared
// RQ10: Compare pins against last access snapshot
// RQ11: ORed mismatches set the port-change flag
// RQ12: Port-change event wakes the core
// RQ13: Any port access refreshes the snapshot
// RQ14: Flag clears by zero write; mismatch resets
// RQ15: Change at read instant may be missed
// RQ16: Software should avoid polling the port
// RQ17: Interrupt and wake need the enable bit
// RQ18: Pull-up on when enabled, input, not reset
`ifndef BPCD_MAP_SVH
`define BPCD_MAP_SVH
`define BPCD_ADDR_DATA 4'h0
`define BPCD_ADDR_DIR 4'h1
`define BPCD_ADDR_OPTION 4'h2
`define BPCD_ADDR_INTCTL 4'h3
`define BPCD_ADDR_ALTEN 4'h4
`define BPCD_ADDR_ALTOUT 4'h5
`define BPCD_ADDR_ALTOE 4'h6
`define BPCD_ADDR_WAKE 4'h7
`define BPCD_BIT_PULLUP_DIS_N 7
`define BPCD_BIT_CHG_FLAG 0
`define BPCD_BIT_CHG_EN 3
`define BPCD_RST_DIR 8'hFF
`define BPCD_RST_OPTION 8'hFF
`define BPCD_RST_LATCH 8'h00
`define BPCD_WAKE_TIME_NS 40
`define BPCD_WAKE_CYC ((`BPCD_WAKE_TIME_NS + 39) / 40)
`endif

// *** hdl/bpcd_pkg.sv ***
package bpcd_pkg;
	typedef logic [7:0] bpcd_byte_t;
	typedef enum logic [1:0] {
		BPCD_RUN = 2'h1,
		BPCD_SLEEP = 2'h2
	} bpcd_pwr_e;
endpackage

// *** hdl/bpcd_pin_cell.sv ***
`timescale 1ns/1ps
module bpcd_pin_cell #(
	parameter int WIDTH = 8
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] dir,
	input wire logic [WIDTH-1:0] latch,
	input wire logic [WIDTH-1:0] alt_en,
	input wire logic [WIDTH-1:0] alt_out,
	input wire logic [WIDTH-1:0] alt_oe,
	input wire logic pullup_disable_n,
	output logic [WIDTH-1:0] pin_out,
	output logic [WIDTH-1:0] pin_oe_n,
	output logic [WIDTH-1:0] pullup_on
);
	logic [WIDTH-1:0] out_next;
	logic [WIDTH-1:0] oe_n_next;
	logic [WIDTH-1:0] pu_next;
	initial begin
		if (WIDTH < 1)
			$error("bpcd_pin_cell: WIDTH must be at least 1");
	end
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			if (alt_en[i]) begin
				out_next[i] = alt_out[i]; // RQ3
				oe_n_next[i] = ~alt_oe[i]; // RQ3
			end else begin
				out_next[i] = latch[i]; // RQ2
				oe_n_next[i] = dir[i]; // RQ1
			end
			// Output enable already covers alternate drive
			pu_next[i] = ~pullup_disable_n & oe_n_next[i]; // RQ6 RQ7 RQ18
		end
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pin_out <= '0;
			pin_oe_n <= '1;
			pullup_on <= '0; // RQ8
		end else begin
			pin_out <= out_next;
			pin_oe_n <= oe_n_next;
			pullup_on <= pu_next;
		end
	end
	out_off_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(alt_en == '0) |=> (pin_oe_n == $past(dir)))
		else $error("direction bit not reflected in enable"); // RQ1
	latch_drive_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(alt_en == '0) |=> ((pin_out & ~pin_oe_n) == ($past(latch) & ~$past(dir))))
		else $error("latch not driven on output pin"); // RQ2
	pullup_out_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(pullup_on & ~pin_oe_n) == '0)
		else $error("pull-up on a driven pin"); // RQ7
endmodule

// *** hdl/bpcd_change_det.sv ***
`timescale 1ns/1ps
module bpcd_change_det #(
	parameter int WIDTH = 4
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [WIDTH-1:0] pins,
	input wire logic [WIDTH-1:0] dir,
	input wire logic access,
	output logic mismatch
);
	logic [WIDTH-1:0] snap_reg;
	logic [WIDTH-1:0] snap_next;
	logic mis_reg;
	logic mis_next;
	initial begin
		if (WIDTH < 1)
			$error("bpcd_change_det: WIDTH must be at least 1");
	end
	always_comb begin
		snap_next = snap_reg;
		if (access)
			snap_next = pins; // RQ13
		// Change in an access cycle lands in the snapshot, not the flag
		mis_next = !access && |((pins ^ snap_reg) & dir); // RQ9 RQ10 RQ11 RQ15
	end
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			snap_reg <= '0;
			mis_reg <= 1'b0;
		end else begin
			snap_reg <= snap_next;
			mis_reg <= mis_next;
		end
	end
	assign mismatch = mis_reg;
	snap_take_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		access |=> (snap_reg == $past(pins)))
		else $error("snapshot not refreshed on access"); // RQ13
	out_excl_a: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(!access && ((pins ^ snap_reg) & dir) == '0) |=> !mismatch)
		else $error("mismatch without input difference"); // RQ9
endmodule

// *** sim/bpcd_pad_model.sv ***
`timescale 1ns/1ps
module bpcd_pad_model (
	input wire logic clk_sys,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe_n,
	input wire logic [7:0] pullup_on,
	input wire logic [7:0] ext_val,
	input wire logic [7:0] ext_en,
	output logic [7:0] pin_in
);
	logic [7:0] last_reg;
	always_ff @(posedge clk_sys) begin
		last_reg <= pin_in;
	end
	// Floating pad shows the inverse of its last level, never a kind value
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pin_oe_n[i]) begin
				pin_in[i] = pin_out[i];
			end else if (ext_en[i]) begin
				pin_in[i] = ext_val[i];
			end else if (pullup_on[i]) begin
				pin_in[i] = 1'b1;
			end else begin
				pin_in[i] = ~last_reg[i];
			end
		end
	end
endmodule

// *** sim/bidir_port_change_detect_tb.sv ***
`timescale 1ns/1ps
module bidir_port_change_detect_tb;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic sleep_req = 1'b0;
	logic [7:0] ext_val = 8'h00;
	logic [7:0] ext_en = 8'hFF;
	logic [7:0] reg_rdata, pin_in, pin_out, pin_oe_n, pullup_on;
	logic irq, wake, asleep;
	logic [7:0] rv, d, l, o, ev;
	int failures = 0;
	int n_tests = 0;
	int seed = 32'h1DF7;
	int k;

	always #20 clk_sys = ~clk_sys;

	bpcd_port dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep_req(sleep_req),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
		.pullup_on(pullup_on), .irq(irq), .wake(wake), .asleep(asleep));
	bpcd_pad_model pad (.clk_sys(clk_sys), .pin_out(pin_out),
		.pin_oe_n(pin_oe_n), .pullup_on(pullup_on), .ext_val(ext_val),
		.ext_en(ext_en), .pin_in(pin_in));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string nm, input logic [7:0] got,
		input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic drv(input logic [7:0] en, input logic [7:0] v);
		@(posedge clk_sys);
		ext_en <= en;
		ext_val <= v;
	endtask
	task automatic end_sim;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	function automatic logic [7:0] exp_pins(input logic [7:0] dv, lv, xv);
		return (lv & ~dv) | (xv & dv);
	endfunction

	////////////////////////////////////////////////////////////////////////
	initial begin
		cyc(16);
		chk("oe_n_rst", pin_oe_n, 8'hFF);
		chk("pullup_rst", pullup_on, 8'h00);
		@(posedge clk_sys);
		sys_rst <= 1'b0;
		rd(4'h1, rv);
		chk("dir_rst", rv, 8'hFF);
		rd(4'h2, rv);
		chk("option_rst", rv, 8'hFF);
		rd(4'hF, rv);
		chk("unmapped", rv, 8'h00);
		for (k = 0; k < 24; k++) begin
			d = 8'($random(seed));
			l = 8'($random(seed));
			o = 8'($random(seed));
			ev = 8'($random(seed));
			if (k < 2) begin
				d = k[0] ? 8'hFF : 8'h00;
				o = k[0] ? 8'h7F : 8'h80;
			end
			wr(4'h2, o);
			wr(4'h0, l);
			wr(4'h1, d);
			drv(d, ev);
			cyc(3);
			chk("oe_n", pin_oe_n, d);
			chk("out", pin_out & ~d, l & ~d);
			chk("pullup", pullup_on, d & {8{~o[7]}});
			rd(4'h0, rv);
			chk("pins", rv, exp_pins(d, l, ev));
		end
		// Alternate function on bit 0 while the direction says input
		wr(4'h1, 8'hFF);
		wr(4'h4, 8'h01);
		wr(4'h5, 8'h01);
		wr(4'h6, 8'h01);
		cyc(3);
		chk("alt_oe", pin_oe_n, 8'hFE);
		chk("alt_out", {7'h00, pin_out[0]}, 8'h01);
		wr(4'h4, 8'h00);
		drv(8'hFF, 8'h00);
		cyc(3);
		rd(4'h0, rv);
		wr(4'h3, 8'h08);
		cyc(2);
		chk("irq_idle", {7'h00, irq}, 8'h00);
		drv(8'hFF, 8'h01);
		cyc(4);
		rd(4'h3, rv);
		chk("lower_nib", rv, 8'h08);
		drv(8'hFF, 8'h11);
		cyc(4);
		chk("irq_set", {7'h00, irq}, 8'h01);
		rd(4'h3, rv);
		chk("flag_set", rv, 8'h09);
		wr(4'h3, 8'h08);
		rd(4'h3, rv);
		chk("flag_sticky", rv, 8'h09);
		rd(4'h0, rv);
		wr(4'h3, 8'h08);
		rd(4'h3, rv);
		chk("flag_clr", rv, 8'h08);
		chk("irq_clr", {7'h00, irq}, 8'h00);
		drv(8'hFF, 8'h01);
		cyc(4);
		wr(4'h3, 8'h01);
		cyc(2);
		chk("irq_mask", {7'h00, irq}, 8'h00);
		rd(4'h3, rv);
		chk("flag_mask", rv, 8'h01);
		rd(4'h0, rv);
		wr(4'h3, 8'h08);
		@(posedge clk_sys);
		sleep_req <= 1'b1;
		@(posedge clk_sys);
		sleep_req <= 1'b0;
		cyc(2);
		chk("asleep", {7'h00, asleep}, 8'h01);
		rd(4'h7, rv);
		chk("sleep_stat", rv, 8'h01);
		drv(8'hFF, 8'h81);
		k = 0;
		while (wake !== 1'b1 && k < 20) begin
			cyc(1);
			k++;
		end
		if (k == 20) begin
			failures++;
			end_sim();
		end
		chk("wake_hi", {7'h00, wake}, 8'h01);
		chk("woke", {7'h00, asleep}, 8'h00);
		cyc(1);
		chk("wake_lo", {7'h00, wake}, 8'h00);
		end_sim();
	end
endmodule
